/* File: core/nic_ctrl_pkg.sv */
// Constants and types shared by the interrupt, reset and power-down control logic.
// Assumes an 8-bit register port with a 4-bit word address and one 50 MHz clock.
package nic_ctrl_pkg;

   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 8;
   localparam int          IRQ_SRC_N       = 8;
   localparam int          LOCAL_IRQ_N     = 4;

   // Register offsets.
   localparam logic [3:0]  OFS_CARD_OPT    = 4'h0;
   localparam logic [3:0]  OFS_CARD_STAT   = 4'h1;
   localparam logic [3:0]  OFS_RX_CTRL     = 4'h2;
   localparam logic [3:0]  OFS_CTRL        = 4'h3;
   localparam logic [3:0]  OFS_CONFIG      = 4'h4;
   localparam logic [3:0]  OFS_ADDR_A      = 4'h5;
   localparam logic [3:0]  OFS_IRQ_STAT    = 4'h6;
   localparam logic [3:0]  OFS_IRQ_MASK    = 4'h7;
   localparam logic [3:0]  OFS_STATE       = 4'h8;

   // Field positions.
   localparam int          CO_FUNC_EN      = 0;
   localparam int          CO_IRQ_EN       = 2;
   localparam int          CO_CFG_SOFT_RESET_BIT       = 7;
   localparam int          CS_INTR         = 1;
   localparam int          CS_PDOWN        = 2;
   localparam int          RX_SOFT_RST     = 7;
   localparam int          CT_WAKE_EN      = 4;
   localparam int          CT_LEGACY_PD    = 5;
   localparam int          CF_ENC_LO       = 0;
   localparam int          CF_SEL_LO       = 2;
   localparam int          ST_LOCAL        = 0;
   localparam int          ST_READY        = 1;
   localparam int          ST_TX_PD        = 2;
   localparam int          ST_RX_PD        = 3;
   localparam int          ST_LINK_PD      = 4;

   // Values after reset.
   localparam logic [7:0]  RST_CARD_OPT    = 8'h00;
   localparam logic [7:0]  RST_CARD_STAT   = 8'h00;
   localparam logic [7:0]  RST_RX_CTRL     = 8'h00;
   localparam logic [7:0]  RST_CTRL        = 8'h00;
   localparam logic [7:0]  RST_CONFIG      = 8'h00;
   localparam logic [7:0]  RST_ADDR_A      = 8'h00;
   localparam logic [7:0]  RST_IRQ         = 8'h00;

   typedef struct packed {
      logic modem;
      logic link;
      logic rx;
      logic tx;
   } pdown_s;

   localparam pdown_s      PD_NONE         = 4'h0;

endpackage : nic_ctrl_pkg

/* File: core/pdown_decode.sv */
// Power-down state decoder for transmit, receive, link and modem.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
module pdown_decode (
   input  wire logic                 pin_active,   // Qualified power-down pin level
   input  wire logic                 local_mode,   // High in local bus mode
   input  wire logic                 func_en,      // Card function enable bit
   input  wire logic                 card_pd,      // Card status power-down bit
   input  wire logic                 legacy_pd,    // Legacy power-down bit
   input  wire logic                 wake_en,      // Wake-up enable bit
   output nic_ctrl_pkg::pdown_s      pd            // Decoded power-down state
);
   import nic_ctrl_pkg::*;

   logic all_down;

   always_comb begin
      pd       = PD_NONE;
      all_down = 1'h0;
      if (pin_active) begin
         // The pin overrides every bit and also stops the modem.
         pd = 4'hF;
      end else if (local_mode) begin
         // Function enable and card power-down are not looked at here.
         all_down = legacy_pd;
         pd.tx    = all_down | wake_en;
         pd.rx    = all_down;
         pd.link  = all_down;
      end else begin
         all_down = ~func_en | card_pd | legacy_pd;
         pd.tx    = all_down | wake_en;
         pd.rx    = all_down | (wake_en & (legacy_pd | card_pd));
         pd.link  = pd.rx;
      end
   end

endmodule : pdown_decode

/* File: core/nic_intr_reset_powerdown_ctrl.sv */
// Interrupt merging, reset routing and power-down control of the Ethernet controller.
// Assumes a host register port with one-cycle strobes and read data one cycle later.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
module nic_intr_reset_powerdown_ctrl (
   input  wire logic                               MCLK,               // 50 MHz clock
   input  wire logic                               RESETN,             // Async reset, low
   input  wire logic [nic_ctrl_pkg::ADDR_W-1:0]    ADDR,               // Register address
   input  wire logic [nic_ctrl_pkg::DATA_W-1:0]    WDATA,              // Write data
   input  wire logic                               WR_STB,             // Write strobe
   input  wire logic                               RD_STB,             // Read strobe
   output logic      [nic_ctrl_pkg::DATA_W-1:0]    RDATA,              // Read data
   input  wire logic                               LOCAL_BUS_SEL,      // Bus mode strap
   input  wire logic [nic_ctrl_pkg::IRQ_SRC_N-1:0] IRQ_EVENTS,         // Source pulses
   input  wire logic                               PDOWN_TXCLK_PIN,    // Power-down pin
   input  wire logic                               EE_LOAD_DONE,       // EEPROM load done
   output logic                                    EE_LOAD_REQ,        // EEPROM read pulse
   output logic                                    CARD_IRQ_READY_N,   // Card irq/ready
   output logic      [nic_ctrl_pkg::LOCAL_IRQ_N-1:0] LOCAL_IRQ_OUTPUTS, // Local irqs
   output logic                                    MODEM_PDOWN_N,      // Modem power-down
   output logic                                    TX_PDOWN,           // Transmit off
   output logic                                    RX_PDOWN,           // Receive off
   output logic                                    LINK_PDOWN,         // Link off
   output logic                                    FUNC_RESET,         // Function reset
   output logic                                    CTRL_RESET,         // Controller reset
   output logic                                    LOCAL_MODE          // Bus mode held
);
   import nic_ctrl_pkg::*;

   logic          rst_q1_r;
   logic          rst_n;
   logic          boot_r;
   logic          local_r;
   logic          ready_r;
   logic [7:0]    card_opt_r;
   logic [7:0]    card_stat_r;
   logic [7:0]    rx_ctrl_r;
   logic [7:0]    ctrl_r;
   logic [7:0]    config_r;
   logic [7:0]    addr_a_r;
   logic [7:0]    irq_stat_r;
   logic [7:0]    irq_mask_r;
   logic          cfg_soft_reset_bit_d_r;
   logic          cfg_soft_reset_bit;
   logic          ctl_rst;
   logic          eth_irq;
   logic          card_irq;
   logic          pin_active;
   logic          ee_start;
   pdown_s        pd_nxt;
   pdown_s        pd_r;
   logic [7:0]    rdata_nxt;

   // Reset release through two flip-flops.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_q1_r <= 1'h0;
         rst_n    <= 1'h0;
      end else begin
         rst_q1_r <= 1'h1;
         rst_n    <= rst_q1_r;
      end
   end

   // Bus mode is caught only once, in the first cycle after hardware reset release.
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         boot_r  <= 1'h1;
         local_r <= 1'h0;
      end else if (boot_r) begin
         boot_r  <= 1'h0;
         local_r <= LOCAL_BUS_SEL;
      end
   end

   wire wr_card_opt = WR_STB && (ADDR == OFS_CARD_OPT);
   wire wr_card_st  = WR_STB && (ADDR == OFS_CARD_STAT);
   wire wr_rx_ctrl  = WR_STB && (ADDR == OFS_RX_CTRL);
   wire wr_ctrl     = WR_STB && (ADDR == OFS_CTRL);
   wire wr_config   = WR_STB && (ADDR == OFS_CONFIG);
   wire wr_addr_a   = WR_STB && (ADDR == OFS_ADDR_A);
   wire wr_irq_stat = WR_STB && (ADDR == OFS_IRQ_STAT);
   wire wr_irq_mask = WR_STB && (ADDR == OFS_IRQ_MASK);

   assign cfg_soft_reset_bit  = card_opt_r[CO_CFG_SOFT_RESET_BIT];
   assign ctl_rst = cfg_soft_reset_bit | rx_ctrl_r[RX_SOFT_RST];

   // Card option register; the soft reset bit survives its own reset.
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         card_opt_r <= RST_CARD_OPT;
      end else if (wr_card_opt) begin
         card_opt_r <= WDATA[CO_CFG_SOFT_RESET_BIT] ? {1'h1, RST_CARD_OPT[6:0]} : WDATA;
      end else if (cfg_soft_reset_bit) begin
         card_opt_r[6:0] <= RST_CARD_OPT[6:0];
      end
   end

   // Card status register: only the power-down bit is stored.
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         card_stat_r <= RST_CARD_STAT;
      end else if (cfg_soft_reset_bit) begin
         card_stat_r <= RST_CARD_STAT;
      end else if (wr_card_st) begin
         card_stat_r[CS_PDOWN] <= WDATA[CS_PDOWN];
      end
   end

   // Receive control: its soft reset bit holds the controller in reset while set.
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         rx_ctrl_r <= RST_RX_CTRL;
      end else if (cfg_soft_reset_bit) begin
         rx_ctrl_r <= RST_RX_CTRL;
      end else if (wr_rx_ctrl) begin
         rx_ctrl_r <= WDATA;
      end
   end

   // Control register with legacy power-down and wake enable.
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= RST_CTRL;
      end else if (ctl_rst) begin
         ctrl_r <= RST_CTRL;
      end else if (wr_ctrl) begin
         ctrl_r <= WDATA;
      end
   end

   // Configuration and address registers are spared by the controller soft reset.
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         config_r <= RST_CONFIG;
         addr_a_r <= RST_ADDR_A;
      end else if (cfg_soft_reset_bit) begin
         config_r <= RST_CONFIG;
         addr_a_r <= RST_ADDR_A;
      end else begin
         if (wr_config) begin
            config_r <= WDATA;
         end
         if (wr_addr_a) begin
            addr_a_r <= WDATA;
         end
      end
   end

   // Sticky interrupt sources; a new event beats a write-one-to-clear.
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= RST_IRQ;
         irq_mask_r <= RST_IRQ;
      end else if (ctl_rst) begin
         irq_stat_r <= RST_IRQ;
         irq_mask_r <= RST_IRQ;
      end else begin
         irq_stat_r <= (irq_stat_r & ~(wr_irq_stat ? WDATA : 8'h00)) | IRQ_EVENTS;
         if (wr_irq_mask) begin
            irq_mask_r <= WDATA;
         end
      end
   end

   assign eth_irq  = |(irq_stat_r & irq_mask_r);
   // The card enable bit gates reporting in card mode only.
   assign card_irq = eth_irq & card_opt_r[CO_IRQ_EN];

   // EEPROM read starts after hardware reset and when the soft reset bit is set.
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         cfg_soft_reset_bit_d_r <= 1'h0;
      end else begin
         cfg_soft_reset_bit_d_r <= cfg_soft_reset_bit;
      end
   end

   assign ee_start = boot_r | (cfg_soft_reset_bit & ~cfg_soft_reset_bit_d_r);

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         EE_LOAD_REQ <= 1'h0;
         ready_r     <= 1'h0;
      end else begin
         EE_LOAD_REQ <= ee_start;
         // A done level left from the previous load is ignored while a request is out.
         if (ee_start || EE_LOAD_REQ) begin
            ready_r <= 1'h0;
         end else if (EE_LOAD_DONE) begin
            ready_r <= 1'h1;
         end
      end
   end

   // Interrupt pins.
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         CARD_IRQ_READY_N  <= 1'h0;
         LOCAL_IRQ_OUTPUTS <= 4'h0;
      end else if (local_r) begin
         CARD_IRQ_READY_N  <= 1'h1;
         LOCAL_IRQ_OUTPUTS <= eth_irq ? (4'h1 << config_r[CF_SEL_LO +: 2]) : 4'h0;
      end else begin
         // Low means not ready, held in soft reset, or enabled interrupt pending.
         CARD_IRQ_READY_N  <= ready_r & ~cfg_soft_reset_bit & ~card_irq;
         LOCAL_IRQ_OUTPUTS <= 4'h0;
      end
   end

   assign pin_active = PDOWN_TXCLK_PIN && (config_r[CF_ENC_LO +: 2] != 2'h0);

   pdown_decode u_pdown (
      .pin_active (pin_active),
      .local_mode (local_r),
      .func_en    (card_opt_r[CO_FUNC_EN]),
      .card_pd    (card_stat_r[CS_PDOWN]),
      .legacy_pd  (ctrl_r[CT_LEGACY_PD]),
      .wake_en    (ctrl_r[CT_WAKE_EN]),
      .pd         (pd_nxt)
   );

   // Power state follows the decoder on every clock.
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         pd_r <= PD_NONE;
      end else begin
         pd_r <= pd_nxt;
      end
   end

   assign TX_PDOWN      = pd_r.tx;
   assign RX_PDOWN      = pd_r.rx;
   assign LINK_PDOWN    = pd_r.link;
   assign MODEM_PDOWN_N = ~pd_r.modem;

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         FUNC_RESET <= 1'h1;
         CTRL_RESET <= 1'h1;
         LOCAL_MODE <= 1'h0;
      end else begin
         FUNC_RESET <= cfg_soft_reset_bit;
         CTRL_RESET <= ctl_rst;
         LOCAL_MODE <= local_r;
      end
   end

   // Read data path; unmapped addresses read zero.
   always_comb begin
      rdata_nxt = 8'h00;
      case (ADDR)
         OFS_CARD_OPT:  rdata_nxt = card_opt_r;
         OFS_CARD_STAT: begin
            rdata_nxt = card_stat_r;
            rdata_nxt[CS_INTR] = eth_irq;
         end
         OFS_RX_CTRL:   rdata_nxt = rx_ctrl_r;
         OFS_CTRL:      rdata_nxt = ctrl_r;
         OFS_CONFIG:    rdata_nxt = config_r;
         OFS_ADDR_A:    rdata_nxt = addr_a_r;
         OFS_IRQ_STAT:  rdata_nxt = irq_stat_r;
         OFS_IRQ_MASK:  rdata_nxt = irq_mask_r;
         OFS_STATE:     rdata_nxt = {3'h0, pd_r.link, pd_r.rx, pd_r.tx, ready_r, local_r};
         default:       rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         RDATA <= 8'h00;
      end else if (RD_STB) begin
         RDATA <= rdata_nxt;
      end else begin
         RDATA <= 8'h00;
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!rst_n);

   chk_irq_local_pin: assert property (
      local_r && eth_irq && !boot_r |=> LOCAL_IRQ_OUTPUTS == (4'h1 << $past(config_r[3:2])))
      else $error("Local interrupt output does not follow merged interrupt.");

   chk_irq_merge_or: assert property (
      local_r && !boot_r && (irq_stat_r & irq_mask_r) == 8'h00 |=> LOCAL_IRQ_OUTPUTS == 4'h0)
      else $error("Local interrupt output set with no enabled source.");

   chk_card_ready_low: assert property (
      !local_r && !ready_r && !boot_r |=> !CARD_IRQ_READY_N)
      else $error("Card request line high before ready.");

   chk_cfg_soft_reset_bit_line_low: assert property (
      !local_r && cfg_soft_reset_bit ##1 !local_r |-> !CARD_IRQ_READY_N)
      else $error("Card line high during configuration soft reset.");

   chk_cfg_soft_reset_bit_ee_req: assert property (
      $rose(cfg_soft_reset_bit) |=> EE_LOAD_REQ ##1 !EE_LOAD_REQ)
      else $error("Soft reset did not give one EEPROM request pulse.");

   chk_ctrl_rst_spare: assert property (
      rx_ctrl_r[RX_SOFT_RST] && !cfg_soft_reset_bit && !wr_config |=> config_r == $past(config_r))
      else $error("Controller soft reset disturbed the config register.");

   chk_ctrl_rst_no_ee: assert property (
      rx_ctrl_r[RX_SOFT_RST] && !cfg_soft_reset_bit && !boot_r && !$rose(cfg_soft_reset_bit) |=> !EE_LOAD_REQ)
      else $error("Controller soft reset started an EEPROM read.");

   chk_pin_gate_enc: assert property (
      config_r[1:0] == 2'h0 ##1 config_r[1:0] == 2'h0 |-> MODEM_PDOWN_N)
      else $error("Pin powered down with encoder select zero.");

   chk_pin_all_down: assert property (
      pin_active |=> !MODEM_PDOWN_N && TX_PDOWN && RX_PDOWN && LINK_PDOWN)
      else $error("Asserted pin did not power down everything.");

   chk_local_wake_tx: assert property (
      local_r && !pin_active && !ctrl_r[5] && ctrl_r[4] |=> TX_PDOWN && !RX_PDOWN && !LINK_PDOWN)
      else $error("Wake enable in local mode did not stop transmit only.");

   chk_local_legacy_pd: assert property (
      local_r && !pin_active && ctrl_r[5] |=> TX_PDOWN && RX_PDOWN && LINK_PDOWN)
      else $error("Legacy power-down bit did not stop all three.");

   chk_local_awake: assert property (
      local_r && !pin_active && ctrl_r[5:4] == 2'h0 |=> !TX_PDOWN && !RX_PDOWN && !LINK_PDOWN)
      else $error("Local mode not fully awake with bits clear.");

   chk_status_intr: assert property (
      RD_STB && ADDR == OFS_CARD_STAT |=> RDATA[CS_INTR] == $past(eth_irq))
      else $error("Status interrupt bit does not show merged interrupt.");

   chk_mode_held: assert property (
      !boot_r |=> local_r == $past(local_r))
      else $error("Bus mode changed after reset release.");

   cov_card_irq: cover property (!local_r && ready_r && card_irq ##1 !CARD_IRQ_READY_N);
   cov_local_irq: cover property (local_r && eth_irq ##1 LOCAL_IRQ_OUTPUTS != 4'h0);
   cov_cfg_soft_reset_bit_cycle: cover property ($rose(cfg_soft_reset_bit) ##[1:20] $fell(cfg_soft_reset_bit));
   cov_pin_down: cover property ($rose(pin_active) ##1 !MODEM_PDOWN_N);

endmodule : nic_intr_reset_powerdown_ctrl

/* File: sim/ee_loader_model.sv */
// Serial configuration memory loader seen from the control block: answers each load request.
// Assumes the request is a one-cycle pulse on the system clock; done stays high until the next request.
`timescale 1ns/1ps
module ee_loader_model #(
   parameter int DELAY = 20
) (
   input  wire logic clk,    // System clock
   input  wire logic rst_n,  // Async reset, low
   input  wire logic req,    // Load request pulse
   output logic      done    // Load finished level
);
   int cnt_r;

   // A new request drops done, so a stale completion never passes for the new load.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 0;
         done  <= 1'b0;
      end else if (req) begin
         cnt_r <= DELAY;
         done  <= 1'b0;
      end else if (cnt_r > 1) begin
         cnt_r <= cnt_r - 1;
      end else if (cnt_r == 1) begin
         cnt_r <= 0;
         done  <= 1'b1;
      end
   end
endmodule : ee_loader_model

/* File: sim/nic_intr_reset_powerdown_ctrl_tb.sv */
// Self-checking bench for the interrupt, reset and power-down control block.
// Assumes the register map and bit positions of nic_ctrl_pkg and a loader model on the far side.
`timescale 1ns/1ps
module nic_intr_reset_powerdown_ctrl_tb;
   import nic_ctrl_pkg::*;
   logic       mclk = 0, rstn = 0, wr_stb = 0, rd_stb = 0, lsel = 1, pin = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, ev_in = 8'h00, rdata, d;
   logic [3:0] lirq, e;
   logic [1:0] enc;
   logic       ee_req, ee_done, card_n, modem_n, tx, rx, link, f_rst, c_rst, lmode;
   int         n_errors = 0, compares = 0, cyc = 0, n_req = 0, k, r;

   nic_intr_reset_powerdown_ctrl i_dut (.MCLK(mclk), .RESETN(rstn), .ADDR(addr), .WDATA(wdata),
      .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .LOCAL_BUS_SEL(lsel), .IRQ_EVENTS(ev_in),
      .PDOWN_TXCLK_PIN(pin), .EE_LOAD_DONE(ee_done), .EE_LOAD_REQ(ee_req),
      .CARD_IRQ_READY_N(card_n), .LOCAL_IRQ_OUTPUTS(lirq), .MODEM_PDOWN_N(modem_n),
      .TX_PDOWN(tx), .RX_PDOWN(rx), .LINK_PDOWN(link), .FUNC_RESET(f_rst), .CTRL_RESET(c_rst),
      .LOCAL_MODE(lmode));
   ee_loader_model i_ee (.clk(mclk), .rst_n(rstn), .req(ee_req), .done(ee_done));

   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (ee_req === 1'b1) n_req++;
      if (cyc > 5000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (n_errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk) {wr_stb, addr, wdata} <= {1'b1, a, v};
      @(posedge mclk) wr_stb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge mclk) {rd_stb, addr} <= {1'b1, a};
      @(posedge mclk) rd_stb <= 1'b0;
      #1 v = rdata;
   endtask : rd
   task automatic ev(input logic [7:0] v);
      @(posedge mclk) ev_in <= v;
      @(posedge mclk) ev_in <= 8'h00;
   endtask : ev
   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask : settle
   task automatic reset_dut(input logic m);
      @(posedge mclk) {rstn, lsel} <= {1'b0, m};
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      repeat (5) @(posedge mclk);
      #1 chk("mode", {7'h0, lmode}, {7'h0, m});
   endtask : reset_dut
   // Returns {modem_pdown_n, link, rx, tx} for local bus mode.
   function automatic logic [3:0] pd_model(bit p, bit enz, bit leg, bit wk);
      if (p && enz) return 4'b0111;
      if (leg) return 4'b1111;
      if (wk) return 4'b1001;
      return 4'b1000;
   endfunction : pd_model

   initial begin
      void'($urandom(53069));
      reset_dut(1'b1);
      for (int i = 0; i < 16; i++) begin
         enc = i[1] ? 2'($urandom_range(1, 3)) : 2'd0;
         @(posedge mclk) pin <= i[0];
         wr(OFS_CONFIG, {6'h00, enc});
         // Card power-down bit is left at 0 in local mode.
         wr(OFS_CARD_OPT, {7'h00, 1'($urandom)});
         wr(OFS_CTRL, {2'b00, i[2], i[3], 4'h0});
         settle();
         e = pd_model(i[0], i[1], i[2], i[3]);
         chk("pdown", {4'h0, modem_n, link, rx, tx}, {4'h0, e});
         rd(OFS_STATE, d);
         chk("state pd", {5'h0, d[4:2]}, {5'h0, e[2:0]});
         chk("state local", {7'h0, d[0]}, 8'h01);
      end
      @(posedge mclk) pin <= 1'b0;
      wr(OFS_CTRL, 8'h00);
      wr(OFS_CARD_OPT, 8'h00);
      for (int s = 0; s < 4; s++) begin
         k = $urandom_range(0, 7);
         wr(OFS_CONFIG, 8'(s << 2));
         wr(OFS_IRQ_MASK, 8'(1 << k));
         ev(~8'(1 << k));
         settle();
         chk("irq masked", {4'h0, lirq}, 8'h00);
         ev(8'(1 << k));
         settle();
         chk("irq local", {4'h0, lirq}, 8'(1 << s));
         chk("card line local", {7'h0, card_n}, 8'h01);
         rd(OFS_CARD_STAT, d);
         chk("intr bit", {7'h0, d[CS_INTR]}, 8'h01);
         wr(OFS_IRQ_STAT, 8'hFF);
         settle();
         chk("irq cleared", {4'h0, lirq}, 8'h00);
      end
      wr(OFS_ADDR_A, 8'h5A);
      wr(OFS_CTRL, 8'h20);
      r = n_req;
      wr(OFS_RX_CTRL, 8'h80);
      settle();
      chk("ctrl reset", {6'h0, f_rst, c_rst}, 8'h01);
      rd(OFS_CTRL, d);
      chk("ctrl cleared", d, 8'h00);
      rd(OFS_ADDR_A, d);
      chk("addr kept", d, 8'h5A);
      rd(OFS_CONFIG, d);
      chk("config kept", d, 8'h0C);
      chk("no load", 8'(n_req), 8'(r));
      wr(OFS_RX_CTRL, 8'h00);
      r = n_req;
      reset_dut(1'b0);
      chk("not ready", {7'h0, card_n}, 8'h00);
      repeat (30) @(posedge mclk);
      #1 chk("ready", {7'h0, card_n}, 8'h01);
      chk("boot load", 8'(n_req), 8'(r + 1));
      wr(OFS_IRQ_MASK, 8'h01);
      wr(OFS_CARD_OPT, 8'h01);
      ev(8'h01);
      settle();
      chk("card irq off", {7'h0, card_n}, 8'h01);
      wr(OFS_CARD_OPT, 8'h05);
      settle();
      chk("card irq", {3'h0, card_n, lirq}, 8'h00);
      wr(OFS_IRQ_STAT, 8'hFF);
      settle();
      chk("card irq clr", {7'h0, card_n}, 8'h01);
      wr(OFS_ADDR_A, 8'h5A);
      r = n_req;
      wr(OFS_CARD_OPT, 8'h80);
      settle();
      chk("cfg_soft_reset_bit line", {6'h0, card_n, f_rst}, 8'h01);
      chk("cfg_soft_reset_bit load", 8'(n_req), 8'(r + 1));
      chk("mode kept", {7'h0, lmode}, 8'h00);
      wr(OFS_CARD_OPT, 8'h00);
      settle();
      chk("line waits load", {7'h0, card_n}, 8'h00);
      repeat (30) @(posedge mclk);
      #1 chk("line raised", {7'h0, card_n}, 8'h01);
      rd(OFS_ADDR_A, d);
      chk("addr reset", d, 8'h00);
      report_and_stop();
   end
endmodule : nic_intr_reset_powerdown_ctrl_tb
